// >>> logic/ums_pkg.sv
/*
  Shared constants for the modem status, scratch and baud generator block:
  register codes, bit positions, reset values and clock figures.
  Assumes a 100 MHz system clock and a 1.8432 MHz reference to synthesise.
*/
// Notes on behaviour
// - status register ignores all writes
// - status at code 110 dual, 0110 single
// - mode 0: control bits; 1: inverted pins
// - change flags track changes since last read
// - flags: cts D0, dsr D1, ring D2, carrier D3
// - D2 catches ring trailing edge
// - D4..D7 show cts, dsr, ring, carrier
// - loop maps rts, dtr, aux reset, enable
// - scratch reachable from both buses together
// - scratch keeps the last write
// - divisor is two write-only bytes
// - divisor at 000/001 only with access bit
// - reference divided by divisor gives 16x clock
// - 16x clock pin gated by control bit
// - divisor write reloads the counter a cycle after the latch
// - loop ignores pins, forces outputs inactive
package ums_pkg;
  localparam logic [2:0] OFS_BAUD_DIVISOR_LOW = 3'h0;
  localparam logic [2:0] OFS_BAUD_DIVISOR_HIGH = 3'h1;
  localparam logic [2:0] OFS_LINE_SIGNAL_STATUS = 3'h6;
  localparam logic [2:0] OFS_SHARED_SCRATCH_BYTE = 3'h7;
  // single-port mode claims only codes with the top address line low
  localparam int UART_ADDR_W = 4;
  localparam int SINGLE_PORT_TOP_LINE = 3;

  // index into the four status lines; flags sit at D0..D3, levels at D4..D7
  localparam int LINE_CTS = 0;
  localparam int LINE_DSR = 1;
  localparam int LINE_RING = 2;
  localparam int LINE_CARRIER = 3;
  localparam int STATUS_LEVEL_LSB = 4;

  // line control outputs register fields
  localparam int LCO_DTR_BIT = 0;
  localparam int LCO_RTS_BIT = 1;
  localparam int LCO_AUX_RESET_BIT = 2;
  localparam int LCO_ENABLE_INT_BIT = 3;
  localparam int LCO_LOOP_BIT = 4;
  // modem control register 1 field that lets the 16x clock out
  localparam int CR1_BAUD_OUT_BIT = 3;

  localparam int DIV_W = 16;
  localparam logic [7:0] SCRATCH_RST = 8'h00;
  localparam logic [DIV_W-1:0] DIVISOR_RST = 16'h0000;
  localparam logic [3:0] LINES_RST = 4'h0;
  localparam logic [3:0] FLAGS_RST = 4'h0;

  localparam longint SYS_CLK_HZ = 100000000;
  localparam longint REF_CLK_HZ = 1843200;
  localparam longint RATE_GRAIN_HZ = 100;
  // fractional accumulator: add REF_STEP per cycle, wrap at REF_MOD
  localparam int REF_STEP = int'(REF_CLK_HZ / RATE_GRAIN_HZ);
  localparam int REF_MOD = int'(SYS_CLK_HZ / RATE_GRAIN_HZ);
  localparam int REF_ACC_W = 20;
endpackage

// >>> logic/ums_baud_if.sv
/*
  Carrier between the register side and the baud generator.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
interface ums_baud_if;
  import ums_pkg::*;
  logic [DIV_W-1:0] divisor;
  logic load;
  logic clk16;
  logic tick16;
  modport ctrl (output divisor, output load, input clk16, input tick16);
  modport gen (input divisor, input load, output clk16, output tick16);
endinterface

// >>> logic/ums_baud_gen.sv
/*
  Programmable baud generator: a fractional accumulator makes the
  1.8432 MHz reference tick, a down-counter divides it by the divisor.
  Assumes clk_en freezes all state and load is a one-cycle pulse.
*/
`timescale 1ns/100ps
module ums_baud_gen
  import ums_pkg::*;
#(
  parameter int DW = DIV_W
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  ums_baud_if.gen bif
);
  if (DW != DIV_W) begin : g_check
    $error("ums_baud_gen: divisor width must match the carrier");
  end

  typedef struct packed {
    logic [REF_ACC_W-1:0] acc;
    logic [DW-1:0] count;
    logic clk16;
    logic tick16;
  } ums_gen_state_t;

  ums_gen_state_t st;
  ums_gen_state_t next_st;
  logic [REF_ACC_W:0] sum;
  logic ref_tick;
  logic [DW-1:0] half;

  always_comb begin
    next_st = st;
    next_st.tick16 = 1'b0;
    sum = {1'b0, st.acc} + (REF_ACC_W+1)'(REF_STEP);
    ref_tick = sum >= (REF_ACC_W+1)'(REF_MOD);
    half = {1'b0, bif.divisor[DW-1:1]};
    if (ref_tick) begin
      next_st.acc = REF_ACC_W'(sum - (REF_ACC_W+1)'(REF_MOD));
    end else begin
      next_st.acc = sum[REF_ACC_W-1:0];
    end
    if (bif.load) begin
      next_st.count = bif.divisor;
    end else if (ref_tick && bif.divisor != '0) begin
      if (st.count <= DW'(1)) begin
        next_st.count = bif.divisor;
        next_st.tick16 = 1'b1;
      end else begin
        next_st.count = st.count - DW'(1);
      end
    end
    next_st.clk16 = next_st.count > half;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign bif.clk16 = st.clk16;
  assign bif.tick16 = st.tick16;
endmodule

// >>> logic/ums_modem_status.sv
/*
  Modem status register with change flags, scratch byte shared by the
  host and modem buses, and the divisor latch feeding the baud generator.
  Assumes one clock, single-cycle read and write strobes on each bus and
  that the rest of the unit multiplexes this block's read data by hit.
*/
`timescale 1ns/100ps
module ums_modem_status
  import ums_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // mode and control bits from the rest of the unit
  input wire logic port_mode_select,
  input wire logic divisor_access_bit,
  input wire logic [7:0] line_control_outputs_reg,
  input wire logic [7:0] modem_ctrl_reg1,
  // status lines as held in the unit control register, active high
  input wire logic [3:0] ctrl_reg_status_lines,
  // external active-low status pins
  input wire logic cts_pin_b,
  input wire logic dsr_pin_b,
  input wire logic ring_pin_b,
  input wire logic carrier_pin_b,
  // host bus
  input wire logic [UART_ADDR_W-1:0] uart_addr_lines,
  input wire logic uart_rd,
  input wire logic uart_wr,
  input wire logic [7:0] uart_wdata,
  output logic [7:0] uart_rdata,
  output logic uart_rdata_hit,
  // modem bus, scratch port
  input wire logic modem_scratch_wr,
  input wire logic [7:0] modem_scratch_wdata,
  output logic [7:0] modem_scratch_rdata,
  // outgoing control lines, active low
  output logic rts_out_b,
  output logic dtr_out_b,
  output logic enable_int_out_b,
  output logic aux_reset_out_b,
  // baud outputs
  output logic baud_tick16,
  output logic baud_clk16_pin
);

  typedef struct packed {
    logic [7:0] scratch;
    logic [DIV_W-1:0] divisor;
    logic divisor_load;
    logic [3:0] prev_lines;
    logic [3:0] chg_flags;
    logic [7:0] rdata;
    logic rdata_hit;
    logic [3:0] ctl_out_b;
    logic clk16_pin;
    logic tick16;
  } ums_state_t;

  ums_state_t st;
  ums_state_t next_st;

  ums_baud_if bif ();

  // decode and source selection
  logic claimed;
  logic [2:0] code;
  logic loop_on;
  logic [3:0] pin_lines;
  logic [3:0] loop_lines;
  logic [3:0] cur_lines;
  logic [3:0] line_change;
  logic [3:0] line_events;
  logic [7:0] status_byte;
  logic status_rd;
  logic scratch_rd;
  logic scratch_wr;
  logic div_low_wr;
  logic div_high_wr;

  always_comb begin
    // dual-port mode uses three lines; single-port adds a fourth, must be 0
    if (port_mode_select) begin
      claimed = !uart_addr_lines[SINGLE_PORT_TOP_LINE];
    end else begin
      claimed = 1'b1;
    end
    code = uart_addr_lines[2:0];
    loop_on = line_control_outputs_reg[LCO_LOOP_BIT];
  end

  always_comb begin
    pin_lines = '0;
    pin_lines[LINE_CTS] = ~cts_pin_b;
    pin_lines[LINE_DSR] = ~dsr_pin_b;
    pin_lines[LINE_RING] = ~ring_pin_b;
    pin_lines[LINE_CARRIER] = ~carrier_pin_b;
    loop_lines = '0;
    loop_lines[LINE_CTS] = line_control_outputs_reg[LCO_RTS_BIT];
    loop_lines[LINE_DSR] = line_control_outputs_reg[LCO_DTR_BIT];
    loop_lines[LINE_RING] =
      line_control_outputs_reg[LCO_AUX_RESET_BIT];
    loop_lines[LINE_CARRIER] =
      line_control_outputs_reg[LCO_ENABLE_INT_BIT];
    if (loop_on) begin
      cur_lines = loop_lines;
    end else if (port_mode_select) begin
      cur_lines = pin_lines;
    end else begin
      cur_lines = ctrl_reg_status_lines;
    end
  end

  always_comb begin
    line_change = cur_lines ^ st.prev_lines;
    line_events = line_change;
    // ring flag only on the indication going away
    line_events[LINE_RING] = st.prev_lines[LINE_RING]
      & ~cur_lines[LINE_RING];
    status_byte = {st.prev_lines, st.chg_flags};
  end

  always_comb begin
    status_rd = 1'b0;
    scratch_rd = 1'b0;
    scratch_wr = 1'b0;
    div_low_wr = 1'b0;
    div_high_wr = 1'b0;
    if (!claimed) begin
      status_rd = 1'b0;
    end else if (code == OFS_LINE_SIGNAL_STATUS) begin
      status_rd = uart_rd;
    end else if (code == OFS_SHARED_SCRATCH_BYTE) begin
      scratch_rd = uart_rd;
      scratch_wr = uart_wr;
    end else if (divisor_access_bit && code == OFS_BAUD_DIVISOR_LOW) begin
      div_low_wr = uart_wr;
    end else if (divisor_access_bit && code == OFS_BAUD_DIVISOR_HIGH) begin
      div_high_wr = uart_wr;
    end
  end

  always_comb begin
    next_st = st;
    next_st.rdata = 8'h00;
    next_st.rdata_hit = 1'b0;
    next_st.divisor_load = 1'b0;
    next_st.tick16 = bif.tick16;

    // status read returns the old flags, then clears; new events win
    next_st.prev_lines = cur_lines;
    if (status_rd) begin
      next_st.rdata = status_byte;
      next_st.rdata_hit = 1'b1;
      next_st.chg_flags = line_events;
    end else begin
      next_st.chg_flags = st.chg_flags | line_events;
    end

    if (scratch_rd) begin
      next_st.rdata = st.scratch;
      next_st.rdata_hit = 1'b1;
    end

    // a modem-bus write in the same cycle is taken as the later one
    if (modem_scratch_wr) begin
      next_st.scratch = modem_scratch_wdata;
    end else if (scratch_wr) begin
      next_st.scratch = uart_wdata;
    end

    if (div_low_wr) begin
      next_st.divisor[7:0] = uart_wdata;
      next_st.divisor_load = 1'b1;
    end
    if (div_high_wr) begin
      next_st.divisor[DIV_W-1:8] = uart_wdata;
      next_st.divisor_load = 1'b1;
    end

    // outgoing controls: active low, held inactive while looped
    if (loop_on) begin
      next_st.ctl_out_b = 4'hf;
    end else begin
      next_st.ctl_out_b[0] = ~line_control_outputs_reg[LCO_RTS_BIT];
      next_st.ctl_out_b[1] = ~line_control_outputs_reg[LCO_DTR_BIT];
      next_st.ctl_out_b[2] =
        ~line_control_outputs_reg[LCO_ENABLE_INT_BIT];
      next_st.ctl_out_b[3] =
        ~line_control_outputs_reg[LCO_AUX_RESET_BIT];
    end

    next_st.clk16_pin = bif.clk16
      & modem_ctrl_reg1[CR1_BAUD_OUT_BIT];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st.scratch <= SCRATCH_RST;
      st.divisor <= DIVISOR_RST;
      st.divisor_load <= 1'b0;
      st.prev_lines <= LINES_RST;
      st.chg_flags <= FLAGS_RST;
      st.rdata <= 8'h00;
      st.rdata_hit <= 1'b0;
      st.ctl_out_b <= 4'hf;
      st.clk16_pin <= 1'b0;
      st.tick16 <= 1'b0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // divisor and its load strobe feed the generator from flops
  assign bif.divisor = st.divisor;
  assign bif.load = st.divisor_load;

  ums_baud_gen #(
    .DW(DIV_W)
  ) u_baud_gen (
    .clk(clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .bif(bif.gen)
  );

  assign uart_rdata = st.rdata;
  assign uart_rdata_hit = st.rdata_hit;
  assign modem_scratch_rdata = st.scratch;
  assign rts_out_b = st.ctl_out_b[0];
  assign dtr_out_b = st.ctl_out_b[1];
  assign enable_int_out_b = st.ctl_out_b[2];
  assign aux_reset_out_b = st.ctl_out_b[3];
  assign baud_tick16 = st.tick16;
  assign baud_clk16_pin = st.clk16_pin;
endmodule

// >>> bench/ums_line_model.sv
/*
  Far-side modem line model: drives the four active-low status pins.
  Assumes pin_lvl holds the asserted state, cts at bit 0.
*/
`timescale 1ns/100ps
module ums_line_model (
  input wire logic [3:0] pin_lvl,
  output logic cts_pin_b,
  output logic dsr_pin_b,
  output logic ring_pin_b,
  output logic carrier_pin_b
);
  assign cts_pin_b = ~pin_lvl[0];
  assign dsr_pin_b = ~pin_lvl[1];
  assign ring_pin_b = ~pin_lvl[2];
  assign carrier_pin_b = ~pin_lvl[3];
endmodule

// >>> bench/ums_checker.sv
/*
  Port-level assertions for the modem status block.
  Assumes it is bound to ums_modem_status with one clock domain.
*/
`timescale 1ns/100ps
module ums_checker
  import ums_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic port_mode_select,
  input wire logic [7:0] line_control_outputs_reg,
  input wire logic [7:0] modem_ctrl_reg1,
  input wire logic [3:0] ctrl_reg_status_lines,
  input wire logic cts_pin_b,
  input wire logic dsr_pin_b,
  input wire logic ring_pin_b,
  input wire logic carrier_pin_b,
  input wire logic [UART_ADDR_W-1:0] uart_addr_lines,
  input wire logic uart_rd,
  input wire logic uart_wr,
  input wire logic [7:0] uart_wdata,
  input wire logic [7:0] uart_rdata,
  input wire logic uart_rdata_hit,
  input wire logic modem_scratch_wr,
  input wire logic [7:0] modem_scratch_wdata,
  input wire logic [7:0] modem_scratch_rdata,
  input wire logic rts_out_b,
  input wire logic dtr_out_b,
  input wire logic enable_int_out_b,
  input wire logic aux_reset_out_b,
  input wire logic baud_tick16,
  input wire logic baud_clk16_pin
);
  logic [7:0] lc;
  logic [3:0] src;
  logic rd6;
  assign lc = line_control_outputs_reg;
  // expected status source: loop first, then pins, then control bits
  assign src = lc[4] ? {lc[3], lc[2], lc[0], lc[1]} : port_mode_select ?
    ~{carrier_pin_b, ring_pin_b, dsr_pin_b, cts_pin_b} :
    ctrl_reg_status_lines;
  assign rd6 = uart_rd && clk_en && uart_addr_lines == 4'h6;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_STATUS_HIT: assert property (rd6 |=> uart_rdata_hit)
    else $error("status read not answered");
  AST_DIV_NO_READ: assert property
    (clk_en && uart_rd && uart_addr_lines[3:1] == 3'h0 |=> !uart_rdata_hit)
    else $error("divisor read answered");
  AST_LEVELS: assert property
    (rd6 && $stable(src) && $past(rst_b) && $past(clk_en) |=>
    uart_rdata[7:4] == $past(src))
    else $error("status levels wrong");
  // flags read back at the second read need the lines still over both gaps
  AST_FLAG_CLEAR: assert property (rd6 && $stable(src) &&
    $past(rst_b) && $past(clk_en) ##1 clk_en && $stable(src) ##1 rd6
    |=> uart_rdata[3:0] == 4'h0)
    else $error("flags not cleared by read");
  AST_LOOP_INACTIVE: assert property (clk_en && lc[4] |=>
    rts_out_b && dtr_out_b && enable_int_out_b && aux_reset_out_b)
    else $error("control outputs active in loop");
  AST_SCRATCH_MODEM: assert property (clk_en && modem_scratch_wr |=>
    modem_scratch_rdata == $past(modem_scratch_wdata))
    else $error("modem scratch write lost");
  AST_SCRATCH_HOST: assert property (clk_en && uart_wr &&
    !modem_scratch_wr && uart_addr_lines == 4'h7 |=>
    modem_scratch_rdata == $past(uart_wdata))
    else $error("host scratch write lost");
  AST_PIN_GATE: assert property
    ((clk_en && !modem_ctrl_reg1[3]) [*2] |=> !baud_clk16_pin)
    else $error("baud pin not gated");
  AST_TICK_PULSE: assert property (clk_en && baud_tick16 |=>
    !baud_tick16)
    else $error("tick longer than a cycle");
endmodule
bind ums_modem_status ums_checker chk (.*);

// >>> bench/ums_modem_status_bench.sv
/*
  Testbench for the modem status, scratch and baud generator block.
  Assumes inputs change on the falling edge and outputs settle by then.
*/
`timescale 1ns/100ps
module ums_modem_status_bench;
  import ums_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  logic port_mode_select = 1'b0;
  logic divisor_access_bit = 1'b0;
  logic [7:0] line_control_outputs_reg = 8'h00;
  logic [7:0] modem_ctrl_reg1 = 8'h00;
  logic [3:0] ctrl_reg_status_lines = 4'h0;
  logic [3:0] pin_lvl = 4'h0;
  logic [3:0] uart_addr_lines = 4'h0;
  logic uart_rd = 1'b0;
  logic uart_wr = 1'b0;
  logic [7:0] uart_wdata = 8'h00;
  logic modem_scratch_wr = 1'b0;
  logic [7:0] modem_scratch_wdata = 8'h00;
  logic cts_pin_b, dsr_pin_b, ring_pin_b, carrier_pin_b, uart_rdata_hit;
  logic rts_out_b, dtr_out_b, enable_int_out_b, aux_reset_out_b;
  logic baud_tick16, baud_clk16_pin;
  logic [3:0] ctl_b;
  logic [7:0] uart_rdata, modem_scratch_rdata;
  int bad_count = 0;
  int total_checks = 0;
  int cur, g, h, e;
  int dv[4] = '{3, 2, 2, 96};
  bit ab[4] = '{1'b1, 1'b0, 1'b1, 1'b1};
  always #5 clk = ~clk;
  ums_modem_status dut (.*);
  ums_line_model peer (.*);
  assign ctl_b = {rts_out_b, dtr_out_b, enable_int_out_b, aux_reset_out_b};
  task give_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task check(input string n, input logic [15:0] s, input logic [15:0] x);
    total_checks++;
    if (s !== x) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, x, s);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    uart_addr_lines = a;
    uart_wdata = d;
    uart_wr = 1'b1;
    @(negedge clk);
    uart_wr = 1'b0;
  endtask
  // checks {hit, data} when c is set
  task rd(input logic [3:0] a, input logic [8:0] x, input bit c);
    @(negedge clk);
    uart_addr_lines = a;
    uart_rd = 1'b1;
    @(negedge clk);
    uart_rd = 1'b0;
    if (c) check("read", {uart_rdata_hit, uart_rdata}, x);
  endtask
  // cycles between two ticks and the number of high pin cycles
  task gap(output int p, output int q);
    int n;
    n = 0;
    p = 0;
    q = 0;
    do begin
      @(negedge clk);
      n++;
    end while (baud_tick16 !== 1'b1 && n < 20000);
    do begin
      @(negedge clk);
      p++;
      q += (baud_clk16_pin === 1'b1);
    end while (baud_tick16 !== 1'b1 && p < 20000);
    if (n >= 20000 || p >= 20000) begin
      bad_count++;
      give_verdict();
    end
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    wr(4'h6, 8'hff);
    rd(4'h6, 9'h100, 1);
    divisor_access_bit = 1'b1;
    rd(4'h0, 9'h000, 1);
    divisor_access_bit = 1'b0;
    wr(4'h7, 8'h5a);
    check("scratch", modem_scratch_rdata, 8'h5a);
    @(negedge clk);
    uart_addr_lines = 4'h7;
    uart_wdata = 8'h11;
    uart_wr = 1'b1;
    modem_scratch_wdata = 8'h22;
    modem_scratch_wr = 1'b1;
    @(negedge clk);
    uart_wr = 1'b0;
    modem_scratch_wr = 1'b0;
    rd(4'h7, 9'h122, 1);
    wr(4'h7, 8'h33);
    rd(4'h7, 9'h133, 1);
    // a write while the enable is low must not land
    clk_en = 1'b0;
    wr(4'h7, 8'h44);
    clk_en = 1'b1;
    check("frozen", modem_scratch_rdata, 8'h33);
    ctrl_reg_status_lines = 4'h5;
    repeat (3) @(negedge clk);
    rd(4'h6, 9'h151, 1);
    rd(4'h6, 9'h150, 1);
    ctrl_reg_status_lines = 4'h0;
    repeat (3) @(negedge clk);
    rd(4'h6, 9'h105, 1);
    port_mode_select = 1'b1;
    pin_lvl = 4'h9;
    repeat (3) @(negedge clk);
    rd(4'h6, 9'h000, 0);
    rd(4'h6, 9'h190, 1);
    rd(4'he, 9'h000, 1);
    line_control_outputs_reg = 8'h0b;
    repeat (2) @(negedge clk);
    check("ctl", ctl_b, 4'h1);
    line_control_outputs_reg = 8'h15;
    pin_lvl = 4'h0;
    repeat (3) @(negedge clk);
    check("ctl", ctl_b, 4'hf);
    rd(4'h6, 9'h000, 0);
    rd(4'h6, 9'h160, 1);
    line_control_outputs_reg = 8'h00;
    port_mode_select = 1'b0;
    modem_ctrl_reg1 = 8'h08;
    cur = 0;
    for (int i = 0; i < 4; i++) begin
      divisor_access_bit = ab[i];
      wr(4'h0, dv[i][7:0]);
      wr(4'h1, dv[i][15:8]);
      if (ab[i]) cur = dv[i];
      e = cur * REF_MOD / REF_STEP;
      gap(g, h);
      check("gap", g >= e && g <= e + 1, 1'b1);
      check("pin", h != 0, 1'b1);
    end
    modem_ctrl_reg1 = 8'h00;
    gap(g, h);
    check("pin", h, 0);
    give_verdict();
  end
endmodule
